// ==== verilog/ssp_rx_map.vh ====
/*
 * Register indices, field positions, reset values and timing counts of the
 * secondary serial port receive slot map (lanes 4 to 6).
 * Assumes the includer uses these names only; byte address is four times an index.
 */
`ifndef SSP_RX_MAP_VH
`define SSP_RX_MAP_VH

// ============================================================
// register indices (byte address = 4 * index)
`define SSP_IDX_LANE4        6'h2B
`define SSP_IDX_LANE5        6'h2C
`define SSP_IDX_LANE6        6'h2D
`define SSP_IDX_FORMAT       6'h30
`define SSP_IDX_STATUS       6'h31

// ============================================================
// reset values
`define SSP_RST_LANE4        8'h03
`define SSP_RST_LANE5        8'h04
`define SSP_RST_LANE6        8'h05
`define SSP_RST_FORMAT       8'h0C

// ============================================================
// field layout
`define SSP_SLOT_MSB         4
`define SSP_SRC_LSB          5
`define SSP_WMASK_LANE4      8'h3F
`define SSP_WMASK_LANE56     8'h7F
`define SSP_WMASK_FORMAT     8'h0F
`define SSP_FMT_FRAMED_BIT   0
`define SSP_FMT_LJ_BIT       1
`define SSP_FMT_WL_LSB       2

// ============================================================
// source codes
`define SSP_SRC_OFF          2'h0
`define SSP_SRC_PLAY         2'h1
`define SSP_SRC_LOOP         2'h2
`define SSP_SRC_LINK         2'h3

// ============================================================
// slot widths in bit clocks, selected by word length code 0..3
`define SSP_WL16             6'h10
`define SSP_WL20             6'h14
`define SSP_WL24             6'h18
`define SSP_WL32             6'h20

`endif

// ==== verilog/ssp_rx_lane.v ====
/*
 * One receive lane: captures the bits of its selected slot and hands the word
 * to the destination named by its source field.
 * Assumes slot position and bit strobes come from the frame tracker on pclk.
 */
module ssp_rx_lane #(
	parameter LINK_OK = 0
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// configuration
	input  wire [1:0]  source,
	input  wire [4:0]  slot,
	// frame position of the current bit
	input  wire        bit_ok,
	input  wire [4:0]  bit_code,
	input  wire        bit_first,
	input  wire        bit_last,
	input  wire        bit_data,
	// captured word
	output reg  [31:0] data,
	output reg         play_valid,
	output reg         loop_valid,
	output reg         link_valid
);
`include "ssp_rx_map.vh"

	reg  [31:0] shift;
	wire        hit;
	wire [31:0] next_shift;

	// ============================================================
	// capture
	// a disabled lane never matches, so its slot field has no effect
	assign hit        = bit_ok && (source != `SSP_SRC_OFF) && (bit_code == slot);
	assign next_shift = {(bit_first ? 31'h00000000 : shift[30:0]), bit_data};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift      <= 32'h00000000;
			data       <= 32'h00000000;
			play_valid <= 1'b0;
			loop_valid <= 1'b0;
			link_valid <= 1'b0;
		end else begin
			play_valid <= 1'b0;
			loop_valid <= 1'b0;
			link_valid <= 1'b0;
			if (hit) begin
				shift <= next_shift;
				if (bit_last) begin
					data       <= next_shift;
					play_valid <= (source == `SSP_SRC_PLAY);
					loop_valid <= (source == `SSP_SRC_LOOP);
					// reserved code 3 goes nowhere on lanes without a chip link
					link_valid <= (source == `SSP_SRC_LINK) && (LINK_OK != 0);
				end
			end
		end
	end
endmodule // ssp_rx_lane

// ==== verilog/ssp_rx_slot_map.v ====
/*
 * Secondary serial port receive slot map for lanes 4 to 6: APB register bank,
 * frame tracker for TDM, I2S and left-justified framing, and three lanes.
 * Assumes bit clock, frame sync and data pins are asynchronous to pclk and the
 * bit clock is slower than pclk/8; data and sync are taken at bit clock rise.
 */
// Functional notes
// - lane 4 source bit 5: clear disables, set routes slot to playback 4.
// - lane 4 slot field bits 4..0, read-write, resets to three.
// - lane 5 source bits 6..5: off, playback 5, ADC 1 loopback, reserved.
// - lane 5 register resets disabled with slot four.
// - lane 6 source: off, playback 6, ADC 2 loopback, chip link device 1.
// - lane 6 register resets disabled with slot five.
module ssp_rx_slot_map (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// serial pins
	input  wire        ssp_bclk,
	input  wire        ssp_fsync,
	input  wire        ssp_sdin,
	// lane 4 destinations
	output wire [31:0] lane4_data,
	output wire        lane4_play_valid,
	// lane 5 destinations
	output wire [31:0] lane5_data,
	output wire        lane5_play_valid,
	output wire        lane5_loop_valid,
	// lane 6 destinations
	output wire [31:0] lane6_data,
	output wire        lane6_play_valid,
	output wire        lane6_loop_valid,
	output wire        lane6_link_valid
);
`include "ssp_rx_map.vh"

	// ============================================================
	// registers
	reg  [7:0]  sec_rx_lane4_select;
	reg  [7:0]  sec_rx_lane5_select;
	reg  [7:0]  sec_rx_lane6_select;
	reg  [7:0]  sec_port_format;
	reg  [7:0]  next_prdata;
	reg         map_hit;
	wire [5:0]  idx;
	wire        aligned;
	wire        wr_en;
	wire [7:0]  status;

	assign idx     = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !map_hit;
	assign wr_en   = psel && penable && pwrite && map_hit && pstrb[0];

	always @* begin
		map_hit     = aligned;
		next_prdata = 8'h00;
		case (idx)
			`SSP_IDX_LANE4:  next_prdata = sec_rx_lane4_select;
			`SSP_IDX_LANE5:  next_prdata = sec_rx_lane5_select;
			`SSP_IDX_LANE6:  next_prdata = sec_rx_lane6_select;
			`SSP_IDX_FORMAT: next_prdata = sec_port_format;
			`SSP_IDX_STATUS: next_prdata = status;
			default:         map_hit = 1'b0;
		endcase
		if (!aligned)
			next_prdata = 8'h00;
	end

	// read data is latched in the setup cycle so it is a flop output in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= {24'h000000, next_prdata};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_rx_lane4_select <= `SSP_RST_LANE4;
			sec_rx_lane5_select <= `SSP_RST_LANE5;
			sec_rx_lane6_select <= `SSP_RST_LANE6;
			sec_port_format     <= `SSP_RST_FORMAT;
		end else if (wr_en) begin
			case (idx)
				`SSP_IDX_LANE4:  sec_rx_lane4_select <= pwdata[7:0] & `SSP_WMASK_LANE4;
				`SSP_IDX_LANE5:  sec_rx_lane5_select <= pwdata[7:0] & `SSP_WMASK_LANE56;
				`SSP_IDX_LANE6:  sec_rx_lane6_select <= pwdata[7:0] & `SSP_WMASK_LANE56;
				`SSP_IDX_FORMAT: sec_port_format     <= pwdata[7:0] & `SSP_WMASK_FORMAT;
				default:         sec_port_format     <= sec_port_format;
			endcase
		end
	end

	// ============================================================
	// pin synchronisers and bit clock edge
	reg  [1:0]  bclk_sync;
	reg  [1:0]  fsync_sync;
	reg  [1:0]  sdin_sync;
	reg         bclk_prev;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_sync  <= 2'h0;
			fsync_sync <= 2'h0;
			sdin_sync  <= 2'h0;
			bclk_prev  <= 1'b0;
		end else begin
			bclk_sync  <= {bclk_sync[0], ssp_bclk};
			fsync_sync <= {fsync_sync[0], ssp_fsync};
			sdin_sync  <= {sdin_sync[0], ssp_sdin};
			bclk_prev  <= bclk_sync[1];
		end
	end

	// ============================================================
	// frame tracker
	reg         fs_prev;
	reg         armed;
	reg         half_right;
	reg  [4:0]  bit_cnt;
	reg  [5:0]  slot_cnt;
	reg  [5:0]  slot_bits;
	wire        edge_rise;
	wire        framed;
	wire        i2s;
	wire        fs;
	wire        start;
	wire        take;
	wire        new_half;
	wire        eff_half;
	wire [4:0]  eff_bit;
	wire [5:0]  eff_slot;
	wire        last_bit;
	wire        bit_ok;
	wire [4:0]  bit_code;

	always @* begin
		case (sec_port_format[`SSP_FMT_WL_LSB+1:`SSP_FMT_WL_LSB])
			2'h0:    slot_bits = `SSP_WL16;
			2'h1:    slot_bits = `SSP_WL20;
			2'h2:    slot_bits = `SSP_WL24;
			default: slot_bits = `SSP_WL32;
		endcase
	end

	assign edge_rise = bclk_sync[1] && !bclk_prev;
	assign framed    = sec_port_format[`SSP_FMT_FRAMED_BIT];
	assign i2s       = framed && !sec_port_format[`SSP_FMT_LJ_BIT];
	assign fs        = fsync_sync[1];
	// TDM frames open on sync rise; I2S/LJ open a half on either sync edge
	assign start     = framed ? (fs != fs_prev) : (fs && !fs_prev);
	// I2S left half runs with sync low, LJ left half with sync high
	assign new_half  = framed && (i2s ? fs : !fs);
	// I2S data lags the sync edge by one bit, so that bit belongs to no slot
	assign take      = edge_rise && (start || armed) && !(start && i2s);
	assign eff_half  = start ? new_half : half_right;
	assign eff_bit   = start ? 5'h00 : bit_cnt;
	assign eff_slot  = start ? 6'h00 : slot_cnt;
	assign last_bit  = ({1'b0, eff_bit} == (slot_bits - 6'h01));
	assign bit_ok    = take && (framed ? (eff_slot[5:4] == 2'h0) : !eff_slot[5]);
	assign bit_code  = framed ? {eff_half, eff_slot[3:0]} : eff_slot[4:0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_prev    <= 1'b0;
			armed      <= 1'b0;
			half_right <= 1'b0;
			bit_cnt    <= 5'h00;
			slot_cnt   <= 6'h00;
		end else if (edge_rise) begin
			fs_prev <= fs;
			if (start) begin
				armed      <= 1'b1;
				half_right <= new_half;
			end
			if (start && i2s) begin
				bit_cnt  <= 5'h00;
				slot_cnt <= 6'h00;
			end else if (take) begin
				bit_cnt <= last_bit ? 5'h00 : eff_bit + 5'h01;
				// slot count parks at 32 once a frame outruns the slot range
				if (last_bit && !eff_slot[5])
					slot_cnt <= eff_slot + 6'h01;
				else
					slot_cnt <= eff_slot;
			end
		end
	end

	assign status = {1'b0, armed, slot_cnt};

	// ============================================================
	// lanes
	ssp_rx_lane #(.LINK_OK(0)) u_lane4 (
		.pclk       (pclk),
		.presetn    (presetn),
		.source     ({1'b0, sec_rx_lane4_select[`SSP_SRC_LSB]}),
		.slot       (sec_rx_lane4_select[`SSP_SLOT_MSB:0]),
		.bit_ok     (bit_ok),
		.bit_code   (bit_code),
		.bit_first  (eff_bit == 5'h00),
		.bit_last   (last_bit),
		.bit_data   (sdin_sync[1]),
		.data       (lane4_data),
		.play_valid (lane4_play_valid),
		.loop_valid (),
		.link_valid ()
	);

	ssp_rx_lane #(.LINK_OK(0)) u_lane5 (
		.pclk       (pclk),
		.presetn    (presetn),
		.source     (sec_rx_lane5_select[`SSP_SRC_LSB+1:`SSP_SRC_LSB]),
		.slot       (sec_rx_lane5_select[`SSP_SLOT_MSB:0]),
		.bit_ok     (bit_ok),
		.bit_code   (bit_code),
		.bit_first  (eff_bit == 5'h00),
		.bit_last   (last_bit),
		.bit_data   (sdin_sync[1]),
		.data       (lane5_data),
		.play_valid (lane5_play_valid),
		.loop_valid (lane5_loop_valid),
		.link_valid ()
	);

	ssp_rx_lane #(.LINK_OK(1)) u_lane6 (
		.pclk       (pclk),
		.presetn    (presetn),
		.source     (sec_rx_lane6_select[`SSP_SRC_LSB+1:`SSP_SRC_LSB]),
		.slot       (sec_rx_lane6_select[`SSP_SLOT_MSB:0]),
		.bit_ok     (bit_ok),
		.bit_code   (bit_code),
		.bit_first  (eff_bit == 5'h00),
		.bit_last   (last_bit),
		.bit_data   (sdin_sync[1]),
		.data       (lane6_data),
		.play_valid (lane6_play_valid),
		.loop_valid (lane6_loop_valid),
		.link_valid (lane6_link_valid)
	);
endmodule // ssp_rx_slot_map

// ==== bench/ssp_rx_slot_map_sva.sv ====
/* checker for ssp_rx_slot_map: shadows the lane registers from apb writes
   and ties lane pulses and reads to them. assumes zero wait state apb. */
module ssp_rx_slot_map_sva (
	// clock, reset, apb
	input wire logic        pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb,
	// lane outputs
	input wire logic [31:0] lane4_data,
	input wire logic        lane4_play_valid, lane5_play_valid, lane5_loop_valid,
	input wire logic        lane6_play_valid, lane6_loop_valid, lane6_link_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] s4, s5, s6;
	wire        wr = psel & penable & pwrite & pready & pstrb[0];
	// ================================================
	// shadow registers, reserved bits masked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s4 <= 8'h03;
			s5 <= 8'h04;
			s6 <= 8'h05;
		end else if (wr) begin
			if (paddr == 8'hAC) s4 <= pwdata[7:0] & 8'h3F;
			if (paddr == 8'hB0) s5 <= pwdata[7:0] & 8'h7F;
			if (paddr == 8'hB4) s6 <= pwdata[7:0] & 8'h7F;
		end
	end
	// ================================================
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_l4_src; lane4_play_valid |-> $past(s4[5]); endproperty
	a_l4_src: assert property (p_l4_src) else $error("lane4 pulse while off");
	property p_l5_play; lane5_play_valid |-> $past(s5[6:5]) == 2'h1; endproperty
	a_l5_play: assert property (p_l5_play) else $error("lane5 play bad");
	property p_l5_loop; lane5_loop_valid |-> $past(s5[6:5]) == 2'h2; endproperty
	a_l5_loop: assert property (p_l5_loop) else $error("lane5 loop bad");
	property p_l6_play; lane6_play_valid |-> $past(s6[6:5]) == 2'h1; endproperty
	a_l6_play: assert property (p_l6_play) else $error("lane6 play bad");
	property p_l6_loop; lane6_loop_valid |-> $past(s6[6:5]) == 2'h2; endproperty
	a_l6_loop: assert property (p_l6_loop) else $error("lane6 loop bad");
	property p_l6_link; lane6_link_valid |-> $past(s6[6:5]) == 2'h3; endproperty
	a_l6_link: assert property (p_l6_link) else $error("lane6 link bad");
	property p_rd4; psel && !penable && !pwrite && paddr == 8'hAC |=> prdata == {24'h0, $past(s4)}; endproperty
	a_rd4: assert property (p_rd4) else $error("lane4 read bad");
	property p_rd5; psel && !penable && !pwrite && paddr == 8'hB0 |=> prdata == {24'h0, $past(s5)}; endproperty
	a_rd5: assert property (p_rd5) else $error("lane5 read bad");
	property p_rd6; psel && !penable && !pwrite && paddr == 8'hB4 |=> prdata == {24'h0, $past(s6)}; endproperty
	a_rd6: assert property (p_rd6) else $error("lane6 read bad");
	property p_hold; $changed(lane4_data) |-> lane4_play_valid; endproperty
	a_hold: assert property (p_hold) else $error("lane4 word moved");
	// one slot per frame, so pulses lie far apart
	property p_gap; lane4_play_valid |=> !lane4_play_valid [*8]; endproperty
	a_gap: assert property (p_gap) else $error("lane4 pulses too close");
	c_l4: cover property (lane4_play_valid);
	c_l5: cover property (lane5_loop_valid);
	c_l6: cover property (lane6_link_valid);
endmodule // ssp_rx_slot_map_sva

// ==== bench/ssp_link_src.sv ====
/* far end of the secondary serial port: sends frames of 16 to 32-bit slots,
   tdm, left-justified or i2s. assumes the bench calls send() and drives no pin. */
module ssp_link_src (
	// serial pins
	output logic bclk, fsync, sdin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
		sdin = 1'b0;
	end
	// one bit clock period; data and sync are set up before the rise
	task automatic tick();
		#80 bclk = 1'b1;
		#80 bclk = 1'b0;
	endtask
	// ================================================
	// one frame, mode 0 tdm, 1 left-justified, 2 i2s; slot code c carries
	// 32'h5A00 | c in wb bits, msb first; the bit clock runs only inside a frame
	task automatic send(input int mode, input int n, input int wb);
		logic [31:0] w;
		#3;
		// i2s needs a sync edge to open the left half, so a spare bit raises it
		if (mode == 2) begin
			fsync = 1'b1;
			sdin = 1'b0;
			tick();
		end
		for (int h = 0; h < (mode != 0 ? 2 : 1); h++) begin
			// i2s: a spare bit carries each sync change, left half with sync low
			if (mode == 2) begin
				fsync = (h == 1);
				sdin = 1'b0;
				tick();
			end
			for (int s = 0; s < n; s++) begin
				w = 32'h5A00 | 32'(h * 16 + s);
				for (int b = wb - 1; b >= 0; b--) begin
					if (mode == 0)
						fsync = (s == 0 && b == wb - 1);
					else if (mode == 1)
						fsync = (h == 0);
					sdin = w[b];
					tick();
				end
			end
		end
		// i2s leaves sync low again so a later tdm frame sees its opening rise
		if (mode == 2) begin
			fsync = 1'b0;
			tick();
		end
		fsync = 1'b0;
		// a released line must not show its last bit
		sdin = ~sdin;
	endtask
endmodule // ssp_link_src

// ==== bench/tb_ssp_rx_slot_map.sv ====
/* bench for ssp_rx_slot_map: register checks over apb and framed traffic
   from the link model. assumes the zero wait state apb of the design. */
module tb_ssp_rx_slot_map;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, d4, d5, d6;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, err, bclk, fsync, sdin;
	wire  [5:0]  v;
	int          cnt [6];
	int          n_mismatch = 0, n_tests = 0;
	always #4 pclk = ~pclk;
	always @(posedge pclk)
		for (int i = 0; i < 6; i++)
			if (v[i] === 1'b1)
				cnt[i]++;
	ssp_link_src ssp_link_src_inst (.bclk(bclk), .fsync(fsync), .sdin(sdin));
	ssp_rx_slot_map ssp_rx_slot_map_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ssp_bclk(bclk), .ssp_fsync(fsync), .ssp_sdin(sdin), .lane4_data(d4),
		.lane4_play_valid(v[5]), .lane5_data(d5), .lane5_play_valid(v[4]), .lane5_loop_valid(v[3]),
		.lane6_data(d6), .lane6_play_valid(v[2]), .lane6_loop_valid(v[1]), .lane6_link_valid(v[0]));
	// ================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("register read", exp, rd);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ================================================
	// scenarios
	task automatic t_reset();
		rdchk(8'hAC, 32'h03);
		rdchk(8'hB0, 32'h04);
		rdchk(8'hB4, 32'h05);
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("reset test done");
	endtask
	task automatic t_regs();
		pstrb <= 4'h0;
		apb(1'b1, 8'hAC, 32'hFF);
		pstrb <= 4'hF;
		rdchk(8'hAC, 32'h03);
		apb(1'b1, 8'hAC, 32'hFF);
		apb(1'b1, 8'hB0, 32'hFF);
		apb(1'b1, 8'hB4, 32'hFF);
		rdchk(8'hAC, 32'h3F);
		rdchk(8'hB0, 32'h7F);
		rdchk(8'hB4, 32'h7F);
		$display("register test done");
	endtask
	task automatic t_frame(input logic [7:0] f, c4, c5, c6, input int mode, n, wb);
		logic [5:0] e;
		e = {c4[5], c5[6:5] == 2'h1, c5[6:5] == 2'h2, c6[6:5] == 2'h1, c6[6:5] == 2'h2, c6[6:5] == 2'h3};
		apb(1'b1, 8'hC0, {24'h0, f});
		apb(1'b1, 8'hAC, {24'h0, c4});
		apb(1'b1, 8'hB0, {24'h0, c5});
		apb(1'b1, 8'hB4, {24'h0, c6});
		cnt = '{default: 0};
		ssp_link_src_inst.send(mode, n, wb);
		repeat (8) @(posedge pclk);
		for (int i = 0; i < 6; i++)
			chk("pulse count", 32'(e[i]), 32'(cnt[i]));
		if (e[5]) chk("lane4 word", 32'h5A00 | c4[4:0], d4);
		if (e[4] | e[3]) chk("lane5 word", 32'h5A00 | c5[4:0], d5);
		if (e[2:0] != 0) chk("lane6 word", 32'h5A00 | c6[4:0], d6);
		$display("frame test done, format %h", f);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_frame(8'h00, 8'h20, 8'h27, 8'h43, 0, 8, 16);
		t_frame(8'h00, 8'h05, 8'h41, 8'h66, 0, 8, 16);
		t_frame(8'h04, 8'h27, 8'h62, 8'h21, 0, 8, 20);
		t_frame(8'h0C, 8'h03, 8'h04, 8'h05, 0, 6, 32);
		t_frame(8'h03, 8'h31, 8'h21, 8'h50, 1, 2, 16);
		t_frame(8'h09, 8'h20, 8'h50, 8'h71, 2, 2, 24);
		finish_test();
	end
	// about twice the expected run of some 780 bit clocks
	initial begin
		#250000;
		n_mismatch++;
		finish_test();
	end
endmodule // tb_ssp_rx_slot_map
bind ssp_rx_slot_map ssp_rx_slot_map_sva ssp_rx_slot_map_sva_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pstrb(pstrb), .lane4_data(lane4_data), .lane4_play_valid(lane4_play_valid),
	.lane5_play_valid(lane5_play_valid), .lane5_loop_valid(lane5_loop_valid),
	.lane6_play_valid(lane6_play_valid), .lane6_loop_valid(lane6_loop_valid),
	.lane6_link_valid(lane6_link_valid));
